// file: rtl/sdc_core.sv
// Purpose: stepper drive control core and its return byte buffer
// Assumes: serial pins asynchronous, sampled by clk (sck up to clk/8)
// Notes: open-drain pins given as output level plus output enable
`default_nettype none
module sdc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sdc_fifo_st_t;
  sdc_fifo_st_t r, nx;
  logic push;
  logic pop;

  assign in_ready  = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];

  always_comb begin
    nx   = r;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      nx.mem[r.wp] = in_data;
      nx.wp        = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      nx.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    nx.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= nx;
    end
  end
endmodule : sdc_fifo

////////////////////////////////////////////////////////////////////////
module sdc_core (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // serial slave pins
  input  wire logic               cs_n_pin,
  input  wire logic               sck_pin,
  input  wire logic               sdi_pin,
  output logic                    sdo_out,
  output logic                    sdo_oe,
  // received bytes and return bytes
  output logic [7:0]              rx_byte,
  output logic                    rx_strobe,
  output logic                    status_read_command,
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  // busy / sync open-drain pin
  input  wire logic               sync_en,
  input  wire logic [2:0]         sync_sel,
  input  wire logic [2:0]         step_sel,
  input  wire logic               step_tick,
  input  wire logic               cmd_running,
  output logic                    busy_sync_out,
  output logic                    busy_sync_oe,
  output logic                    status_busy,
  // alarms
  input  wire logic [9:0]         alarm_cond,
  input  wire logic [9:0]         alarm_en,
  output logic [9:0]              status_flags_n,
  output logic                    stall_a_n,
  output logic                    stall_b_n,
  output logic                    flag_out,
  output logic                    flag_oe,
  // amplitude
  input  wire sdc_pkg::sdc_phase_t motion_phase,
  input  wire logic [7:0]         amplitude_accel_start,
  input  wire logic [7:0]         amplitude_decel_start,
  input  wire logic [7:0]         amplitude_run_start,
  input  wire logic [7:0]         amplitude_hold_start,
  input  wire logic [13:0]        speed,
  input  wire logic [13:0]        int_speed,
  input  wire logic [7:0]         start_slope,
  input  wire logic [7:0]         final_slope_accel,
  input  wire logic [7:0]         final_slope_decel,
  input  wire logic [3:0]         winding_thermal_factor,
  input  wire logic               supply_comp_enable,
  input  wire logic [4:0]         converter_input_pin,
  input  wire logic [7:0]         microstep_a,
  input  wire logic [7:0]         microstep_b,
  output logic [4:0]              adc_out,
  output logic [7:0]              supply_voltage_factor,
  output logic [7:0]              backemf_curve_value,
  output logic [7:0]              duty_a,
  output logic [7:0]              duty_b,
  // pwm
  input  wire logic [2:0]         pwm_divider,
  input  wire logic [2:0]         pwm_multiplier,
  output logic                    pwm_a,
  output logic                    pwm_b,
  output logic                    pwm_period_strobe,
  // low speed optimisation
  input  wire logic               low_speed_optimise_bit,
  input  wire logic [11:0]        min_speed,
  output logic [11:0]             profile_min_speed,
  output logic                    low_speed_active
);
  import sdc_pkg::*;

  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sck_s;
    logic [1:0]  sdi_s;
    logic        cs_d;
    logic        sck_d;
    logic [7:0]  sh;
    logic [2:0]  bitcnt;
    logic        sdo;
    logic        sdo_oe;
    logic [7:0]  rx;
    logic        rx_stb;
    logic        rx_full;
    logic        st_rd;
    logic [9:0]  flg_n;
    logic        flag_oe;
    logic        busy_oe;
    logic        busy_st;
    logic [7:0]  step_cnt;
    logic [8:0]  pwm_cnt;
    logic [7:0]  pacc;
    logic        per_stb;
    logic [4:0]  adc;
    logic [7:0]  vsf;
    logic [7:0]  bemf;
    logic [7:0]  duty_a;
    logic [7:0]  duty_b;
    logic        pwm_a;
    logic        pwm_b;
    logic        lspd_act;
    logic [11:0] prof_min;
  } sdc_st_t;

  sdc_st_t r, nx;
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;

  // saturate a wide value to one byte
  function automatic logic [7:0] sat8(input logic [23:0] v);
    sat8 = (v > 24'h0000FF) ? 8'hFF : v[7:0];
  endfunction : sat8

  // weight the amplitude by a microstep fraction of peak
  function automatic logic [7:0] ustep_scale(input logic [7:0] amp, input logic [7:0] us);
    logic [15:0] p;
    p = amp * us;
    ustep_scale = p[15:8];
  endfunction : ustep_scale

  sdc_fifo #(
    .W (TX_FIFO_WIDTH),
    .D (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // return byte is taken only at the end of a frame
  assign fifo_pop = r.cs_s[1] && !r.cs_d; // R22

  always_comb begin
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic [7:0]  kstart;
    logic [7:0]  fslope;
    logic [23:0] bcurve;
    logic [8:0]  ksum;
    logic [15:0] vprod;
    logic [13:0] tprod;
    logic [7:0]  kvs;
    logic [7:0]  kth;
    logic [2:0]  sexp;
    logic [7:0]  mstep;
    logic [6:0]  thr;
    logic [8:0]  nacc;
    logic [1:0]  inc;
    logic [9:0]  ncnt;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall  = 1'b0;
    kstart   = '0;
    fslope   = '0;
    bcurve   = '0;
    ksum     = '0;
    vprod    = '0;
    tprod    = '0;
    kvs      = '0;
    kth      = '0;
    sexp     = '0;
    mstep    = '0;
    thr      = '0;
    nacc     = '0;
    inc      = '0;
    ncnt     = '0;
    nx       = r;

    ////////////////////////////////////////////////////////////////////
    // serial slave
    nx.cs_s   = {r.cs_s[0], cs_n_pin};
    nx.sck_s  = {r.sck_s[0], sck_pin};
    nx.sdi_s  = {r.sdi_s[0], sdi_pin};
    nx.cs_d   = r.cs_s[1];
    nx.sck_d  = r.sck_s[1];
    nx.rx_stb = 1'b0;
    nx.st_rd  = 1'b0;
    sck_rise  = r.sck_s[1] && !r.sck_d && !r.cs_s[1];
    sck_fall  = !r.sck_s[1] && r.sck_d && !r.cs_s[1];
    cs_fall   = !r.cs_s[1] && r.cs_d;
    nx.sdo_oe = !r.cs_s[1]; // R18
    if (cs_fall) begin
      nx.bitcnt  = '0;
      nx.rx_full = 1'b0;
      nx.sdo     = r.sh[7]; // R20
    end
    if (sck_rise) begin
      // bits walk through, so chained devices pass the previous byte on
      nx.sh     = {r.sh[6:0], r.sdi_s[1]}; // R19 R24
      nx.bitcnt = r.bitcnt + 3'h1;
      if (r.bitcnt == 3'h7) begin
        nx.rx      = {r.sh[6:0], r.sdi_s[1]};
        nx.rx_stb  = 1'b1;
        nx.rx_full = 1'b1;
      end
    end
    if (sck_fall) begin
      nx.sdo = r.sh[7]; // R20
    end
    if (fifo_pop) begin
      // decode during deselect, then load the return value
      nx.st_rd = r.rx_full && (r.rx == STATUS_READ_OPCODE); // R22
      nx.sh    = fifo_valid ? fifo_data : ZERO_BYTE; // R21 R22
    end

    ////////////////////////////////////////////////////////////////////
    // alarm flags: a new event wins over a status read
    for (int i = 0; i < NFLG; i++) begin
      if (alarm_cond[i]) begin
        nx.flg_n[i] = 1'b0; // R6 R12
      end else if (r.st_rd) begin
        nx.flg_n[i] = 1'b1; // R12 R23
      end
    end
    nx.flag_oe = |(~nx.flg_n & alarm_en); // R6 R7

    ////////////////////////////////////////////////////////////////////
    // busy / sync pin
    if (step_tick) begin
      nx.step_cnt = r.step_cnt + 8'h01;
    end
    sexp = (step_sel > sync_sel) ? step_sel - sync_sel : 3'h0;
    if (sync_en) begin
      nx.busy_oe = !r.step_cnt[sexp]; // R5
    end else begin
      nx.busy_oe = cmd_running; // R1 R2 R3
    end
    nx.busy_st = !nx.busy_oe; // R4

    ////////////////////////////////////////////////////////////////////
    // pwm timebase: counter advances m/N per clock, 512 counts a period
    thr  = 7'(PWM_M_DEN) * 7'({1'b0, pwm_divider} + 4'h1);
    nacc = {1'b0, r.pacc} + 9'({1'b0, pwm_multiplier} + PWM_M_OFS);
    if (nacc >= {thr, 1'b0}) begin
      inc  = 2'h2;
      nacc = nacc - 9'({thr, 1'b0});
    end else if (nacc >= 9'(thr)) begin
      inc  = 2'h1;
      nacc = nacc - 9'(thr);
    end
    nx.pacc    = nacc[7:0];
    ncnt       = {1'b0, r.pwm_cnt} + 10'(inc); // R11
    nx.pwm_cnt = ncnt[8:0];
    nx.per_stb = ncnt[9];
    if (r.per_stb) begin
      // converter sampled once per period, compensation or not
      nx.adc = converter_input_pin; // R16
      if (supply_comp_enable) begin
        nx.vsf = (converter_input_pin == 5'h00) ? 8'hFF
               : sat8(24'(VS_NUM / 16'(converter_input_pin))); // R16
      end else begin
        nx.vsf = VS_ONE; // R16
      end
    end

    ////////////////////////////////////////////////////////////////////
    // amplitude
    unique case (motion_phase)
      PH_ACC:  kstart = amplitude_accel_start; // R9
      PH_DEC:  kstart = amplitude_decel_start; // R9
      PH_RUN:  kstart = amplitude_run_start; // R9
      PH_HOLD: kstart = amplitude_hold_start; // R9
    endcase
    fslope = (motion_phase == PH_DEC) ? final_slope_decel : final_slope_accel; // R14 R15
    if (speed < int_speed) begin
      bcurve = 24'(speed * start_slope); // R14
    end else begin
      bcurve = 24'(int_speed * start_slope) + 24'((speed - int_speed) * fslope); // R14
    end
    nx.bemf = (motion_phase == PH_HOLD) ? 8'h00 : sat8(bcurve >> BEMF_SHIFT); // R15
    ksum    = {1'b0, kstart} + {1'b0, r.bemf}; // R10
    vprod   = sat8(24'(ksum)) * r.vsf; // R8 R10
    kvs     = sat8(24'(vprod >> Q5_SHIFT));
    tprod   = kvs * (KT_ONE + 6'(winding_thermal_factor)); // R17
    kth     = sat8(24'(tprod >> Q5_SHIFT));
    mstep   = kth;
    nx.duty_a = ustep_scale(mstep, microstep_a); // R10
    nx.duty_b = ustep_scale(mstep, microstep_b); // R10
    nx.pwm_a  = r.pwm_cnt[8:1] < r.duty_a; // R11
    nx.pwm_b  = r.pwm_cnt[8:1] < r.duty_b; // R11

    ////////////////////////////////////////////////////////////////////
    // low speed optimisation
    nx.lspd_act = low_speed_optimise_bit && (speed <= 14'(min_speed)); // R13
    nx.prof_min = low_speed_optimise_bit ? 12'h000 : min_speed; // R13
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r         <= '0;
      r.cs_s    <= 2'h3;
      r.cs_d    <= 1'b1;
      r.flg_n   <= FLG_RST;
      r.flag_oe <= 1'b1;
      r.busy_st <= 1'b1;
      r.vsf     <= VS_ONE;
    end else if (ce) begin
      r <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign sdo_out               = r.sdo;
  assign sdo_oe                = r.sdo_oe;
  assign rx_byte               = r.rx;
  assign rx_strobe             = r.rx_stb;
  assign status_read_command   = r.st_rd;
  assign busy_sync_out         = 1'b0;
  assign busy_sync_oe          = r.busy_oe;
  assign status_busy           = r.busy_st;
  assign status_flags_n        = r.flg_n;
  assign stall_a_n             = r.flg_n[FLG_STALL_A];
  assign stall_b_n             = r.flg_n[FLG_STALL_B];
  assign flag_out              = 1'b0;
  assign flag_oe               = r.flag_oe;
  assign adc_out               = r.adc;
  assign supply_voltage_factor = r.vsf;
  assign backemf_curve_value   = r.bemf;
  assign duty_a                = r.duty_a;
  assign duty_b                = r.duty_b;
  assign pwm_a                 = r.pwm_a;
  assign pwm_b                 = r.pwm_b;
  assign pwm_period_strobe     = r.per_stb;
  assign profile_min_speed     = r.prof_min;
  assign low_speed_active      = r.lspd_act;
endmodule : sdc_core
`default_nettype wire

// file: rtl/sdc_pkg.sv
// Purpose: constants and types of the stepper drive control core
// Assumes: 50 MHz system clock, all logic in one clock domain
// Notes: flags are active low, as on the status word
// Functional notes
// R1 - shared pin is busy when sync off
// R2 - busy pin low while motion command runs
// R3 - busy pin released when command completes
// R4 - status bit mirrors busy pin level
// R5 - sync mode outputs selected step clock
// R6 - alarm pin low on any unmasked condition
// R7 - mask only gates alarm pin
// R8 - phase amplitude is supply times factor
// R9 - starting factor chosen by motion phase
// R10 - amplitude formula with compensations and microstep
// R11 - two PWM modulators at fosc/(512N)*m
// R12 - stall flags low until status read
// R13 - low speed optimise zeroes profile minimum
// R14 - back-EMF curve has two slopes
// R15 - accel curve running, none when stopped
// R16 - supply compensation optional, sample per period
// R17 - thermal factor multiplies duty value
// R18 - byte slave, output off when deselected
// R19 - input sampled on rising clock, msb first
// R20 - output changed on falling clock, msb first
// R21 - zero byte when nothing to return
// R22 - deselect after byte, then decode and load
// R23 - flag released after condition end and read
// R24 - daisy chain passes previous byte through
`default_nettype none
package sdc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PWM_STEPS = 512;
  localparam int unsigned PWM_CNT_W = 9;
  localparam logic [3:0] PWM_M_OFS = 4'h5;
  localparam logic [3:0] PWM_M_DEN = 4'h8;
  localparam logic [15:0] VS_NUM = 16'h0200;
  localparam logic [7:0] VS_ONE = 8'h20;
  localparam logic [5:0] KT_ONE = 6'h20;
  localparam int unsigned Q5_SHIFT = 5;
  localparam int unsigned BEMF_SHIFT = 12;
  localparam int unsigned NFLG = 10;
  localparam int unsigned FLG_PWRUP = 0;
  localparam int unsigned FLG_STALL_A = 1;
  localparam int unsigned FLG_STALL_B = 2;
  localparam int unsigned FLG_OCD = 3;
  localparam int unsigned FLG_TH_WRN = 4;
  localparam int unsigned FLG_TH_SD = 5;
  localparam int unsigned FLG_UVLO = 6;
  localparam int unsigned FLG_SW_EVN = 7;
  localparam int unsigned FLG_WRONG = 8;
  localparam int unsigned FLG_NOTPERF = 9;
  localparam logic [9:0] FLG_RST = 10'h3BE;
  localparam logic [7:0] STATUS_READ_OPCODE = 8'hD0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int unsigned TX_FIFO_DEPTH = 8;
  localparam int unsigned TX_FIFO_WIDTH = 8;
  typedef enum logic [1:0] {
    PH_HOLD,
    PH_ACC,
    PH_DEC,
    PH_RUN
  } sdc_phase_t;
endpackage : sdc_pkg
`default_nettype wire

// file: test/sdc_core_monitor.sv
// Purpose: port assertions for the stepper drive control core
// Assumes: one clock domain, rstn asynchronous and active low
// Notes: bound into every sdc_core instance
`default_nettype none
module sdc_core_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        cs_n_pin,
  input wire logic        sdo_oe,
  input wire logic        status_read_command,
  input wire logic        rx_strobe,
  input wire logic        sync_en,
  input wire logic        cmd_running,
  input wire logic        busy_sync_oe,
  input wire logic        status_busy,
  input wire logic [9:0]  alarm_cond,
  input wire logic [9:0]  alarm_en,
  input wire logic [9:0]  status_flags_n,
  input wire logic        stall_a_n,
  input wire logic        stall_b_n,
  input wire logic        flag_oe,
  input wire logic        low_speed_optimise_bit,
  input wire logic [11:0] min_speed,
  input wire logic [11:0] profile_min_speed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_desel;
    cs_n_pin [*6];
  endsequence
  sequence s_read_clear;
    (status_read_command && alarm_cond == 10'h000) ##1 (alarm_cond == 10'h000);
  endsequence
  property p_busy_on;  !sync_en && cmd_running |=> busy_sync_oe; endproperty
  property p_busy_off; !sync_en && !cmd_running |=> !busy_sync_oe; endproperty
  property p_mirror;   status_busy == !busy_sync_oe; endproperty
  property p_flag_pin; (alarm_cond & alarm_en) != 10'h000 |=> flag_oe; endproperty
  property p_flag_latch;
    alarm_cond != 10'h000 |=> (status_flags_n & $past(alarm_cond)) == 10'h000;
  endproperty
  property p_stall_hold; !stall_a_n && !status_read_command |=> !stall_a_n; endproperty
  property p_stall_map;
    stall_a_n == status_flags_n[1] && stall_b_n == status_flags_n[2];
  endproperty
  property p_desel;    s_desel |-> !sdo_oe; endproperty
  property p_rx_pulse; rx_strobe |=> !rx_strobe; endproperty
  property p_release;  s_read_clear |-> status_flags_n == 10'h3FF; endproperty
  property p_lspd_on;  low_speed_optimise_bit |=> profile_min_speed == 12'h000; endproperty
  property p_lspd_off;
    !low_speed_optimise_bit |=> profile_min_speed == $past(min_speed);
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("busy pin not low while running");
  a_busy_off: assert property (p_busy_off)
    else $error("busy pin not released");
  a_mirror: assert property (p_mirror)
    else $error("busy status bit differs from pin");
  a_flag_pin: assert property (p_flag_pin)
    else $error("alarm pin not low");
  a_flag_latch: assert property (p_flag_latch)
    else $error("flag not latched low");
  a_stall_hold: assert property (p_stall_hold)
    else $error("stall flag released early");
  a_stall_map: assert property (p_stall_map)
    else $error("stall outputs differ from flags");
  a_desel: assert property (p_desel)
    else $error("serial out driven while deselected");
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("byte strobe longer than one cycle");
  a_release: assert property (p_release)
    else $error("flags not released after status read");
  a_lspd_on: assert property (p_lspd_on)
    else $error("profile minimum not forced to zero");
  a_lspd_off: assert property (p_lspd_off)
    else $error("profile minimum not passed through");
endmodule : sdc_core_monitor
bind sdc_core sdc_core_monitor i_mon (.*);
`default_nettype wire

// file: test/sdc_host_model.sv
// Purpose: host serial master facing the core
// Assumes: serial clock idles low, 160 ns bit period
// Notes: caller opens and closes each frame
`default_nettype none
module sdc_host_model (
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic open_frame();
    cs_n = 1'b0;
    #200;
  endtask : open_frame
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      #80 sck = 1'b1;
      #70 q[i] = sdo;
      #10 sck = 1'b0;
    end
  endtask : xfer
  task automatic close_frame();
    #80 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask : close_frame
endmodule : sdc_host_model
`default_nettype wire

// file: test/stepper_drive_control_core_tb_top.sv
// Purpose: self-checking bench of the stepper drive control core
// Assumes: 50 MHz clock, host model on the serial pins
// Notes: random configuration from a fixed seed
`default_nettype none
module stepper_drive_control_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;
  logic        clk, rstn, ce, cs_n_pin, sck_pin, sdi_pin, sdo_w, sdo_out, sdo_oe;
  logic        rx_strobe, status_read_command, tx_valid, tx_ready, sync_en, step_tick;
  logic        cmd_running, busy_sync_out, busy_sync_oe, status_busy, stall_a_n, stall_b_n;
  logic        flag_out, flag_oe, supply_comp_enable, pwm_a, pwm_b, pwm_period_strobe;
  logic        low_speed_optimise_bit, low_speed_active;
  logic        sdo_last = 1'b0;
  logic [2:0]  sync_sel, step_sel, pwm_divider, pwm_multiplier;
  logic [3:0]  winding_thermal_factor;
  logic [4:0]  converter_input_pin, adc_out;
  logic [7:0]  rx_byte, tx_data, amplitude_accel_start, amplitude_decel_start, amplitude_run_start;
  logic [7:0]  amplitude_hold_start, start_slope, final_slope_accel, final_slope_decel;
  logic [7:0]  microstep_a, microstep_b, supply_voltage_factor, backemf_curve_value;
  logic [7:0]  duty_a, duty_b, q, q2, d, ex;
  logic [9:0]  alarm_cond, alarm_en, status_flags_n;
  logic [11:0] min_speed, profile_min_speed;
  logic [13:0] speed, int_speed;
  sdc_phase_t  motion_phase;
  int          err_count = 0, checks = 0, cyc = 0, t, ticks = 0;
  logic [7:0]  fifo_q[$];
  sdc_core       i_dut (.*);
  sdc_host_model i_host (.cs_n(cs_n_pin), .sck(sck_pin), .sdi(sdi_pin), .sdo(sdo_w));
  // released line shows the inverse of its last driven level
  assign sdo_w = sdo_oe ? sdo_out : ~sdo_last;
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo_out;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic flag_pin(input logic [9:0] en, input logic [9:0] c);
    return |(en & c);
  endfunction : flag_pin
  // period in clocks is 512 * N / m, with N = code + 1 and m = (mult + 5) / 8
  function automatic int pwm_period(input int code);
    return PWM_STEPS * int'(PWM_M_DEN) * (code + 1) / (int'(pwm_multiplier) + int'(PWM_M_OFS));
  endfunction : pwm_period
  function automatic int sat8i(input int v);
    return (v > 255) ? 255 : v;
  endfunction : sat8i
  // supply factor in Q5, unity when compensation is off
  function automatic int vsf_exp();
    if (!supply_comp_enable) return VS_ONE;
    return (converter_input_pin == 5'h00) ? 255 : sat8i(VS_NUM / converter_input_pin);
  endfunction : vsf_exp
  // two-segment back-EMF line, none while holding
  function automatic int bemf_exp();
    int c;
    c = (motion_phase == PH_DEC) ? final_slope_decel : final_slope_accel;
    c = (speed < int_speed) ? speed * start_slope : int_speed * start_slope + (speed - int_speed) * c;
    return (motion_phase == PH_HOLD) ? 0 : sat8i(c >> BEMF_SHIFT);
  endfunction : bemf_exp
  function automatic int duty_exp(input int b);
    int k;
    case (motion_phase)
      PH_ACC:  k = amplitude_accel_start;
      PH_DEC:  k = amplitude_decel_start;
      PH_RUN:  k = amplitude_run_start;
      default: k = amplitude_hold_start;
    endcase
    k = sat8i(sat8i(k + b) * vsf_exp() >> Q5_SHIFT);
    k = sat8i(k * (KT_ONE + winding_thermal_factor) >> Q5_SHIFT);
    return k * microstep_b >> 8;
  endfunction : duty_exp
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic frame(input logic [7:0] b, output logic [7:0] r);
    i_host.open_frame();
    i_host.xfer(b, r);
    i_host.close_frame();
  endtask : frame
  task automatic get_status();
    frame(STATUS_READ_OPCODE, q);
    step(2);
  endtask : get_status
  task automatic wait_strobe();
    int k;
    k = 0;
    do begin
      step(1);
      k++;
    end while (pwm_period_strobe !== 1'b1 && k < 10000);
  endtask : wait_strobe
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h75C30929));
    {amplitude_accel_start, amplitude_decel_start, amplitude_run_start, amplitude_hold_start} = $urandom;
    {start_slope, final_slope_accel, final_slope_decel, microstep_b} = $urandom;
    {speed, int_speed, winding_thermal_factor} = $urandom;
    {converter_input_pin, sync_sel, step_sel, min_speed, microstep_a, supply_comp_enable} = $urandom;
    motion_phase = sdc_phase_t'($urandom_range(3));
    {rstn, ce, tx_valid, tx_data, sync_en, step_tick, cmd_running} = 14'h1000;
    {alarm_cond, alarm_en, low_speed_optimise_bit} = 21'h007FE;
    {pwm_divider, pwm_multiplier} = 6'h03;
    step(5);
    rstn = 1'b1;
    step(3);
    chk("flags", FLG_RST, status_flags_n);
    chk("flag_oe", 1'b1, flag_oe);
    chk("busy", 1'b1, status_busy);
    chk("sdo_oe", 1'b0, sdo_oe);
    chk("od_lvl", 2'b00, {busy_sync_out, flag_out});
    get_status();
    chk("ret", ZERO_BYTE, q);
    chk("flags", 10'h3FF, status_flags_n);
    for (int i = 0; i < NFLG; i++) begin
      alarm_en = 10'($urandom);
      alarm_en[i] = i[0];
      alarm_cond = 10'h001 << i;
      step(2);
      chk("flag_oe", flag_pin(alarm_en, alarm_cond), flag_oe);
      get_status();
      chk("held", 1'b0, status_flags_n[i]);
      alarm_cond = 10'h000;
      step(1);
      get_status();
      chk("released", 10'h3FF, status_flags_n);
      chk("flag_oe", 1'b0, flag_oe);
    end
    while (tx_ready === 1'b1 && fifo_q.size() < 12) begin
      tx_data = 8'($urandom);
      tx_valid = 1'b1;
      fifo_q.push_back(tx_data);
      step(1);
    end
    tx_valid = 1'b0;
    chk("fill", 16'(TX_FIFO_DEPTH), 16'(fifo_q.size()));
    chk("full", 1'b0, tx_ready);
    ex = ZERO_BYTE;
    repeat (9) begin
      d = 8'($urandom);
      frame(d, q);
      chk("ret", ex, q);
      chk("rx", d, rx_byte);
      ex = (fifo_q.size() > 0) ? fifo_q.pop_front() : ZERO_BYTE;
    end
    chk("ready", 1'b1, tx_ready);
    i_host.open_frame();
    i_host.xfer(8'hA5, q);
    i_host.xfer(8'h3C, q2);
    i_host.close_frame();
    chk("chain0", ZERO_BYTE, q);
    chk("chain1", 8'hA5, q2);
    chk("rx", 8'h3C, rx_byte);
    cmd_running = 1'b1;
    step(3 + $urandom_range(20));
    chk("busy_pin", 1'b1, busy_sync_oe);
    chk("busy_bit", 1'b0, status_busy);
    cmd_running = 1'b0;
    step(2);
    chk("busy_pin", 1'b0, busy_sync_oe);
    sync_en = 1'b1;
    sync_sel = 3'h1;
    step_sel = 3'($urandom_range(5, 1));
    repeat (64) begin
      step_tick = ~step_tick;
      step(1);
      chk("sync_pin", !ticks[step_sel - sync_sel], busy_sync_oe);
      ticks += step_tick;
    end
    sync_en = 1'b0;
    low_speed_optimise_bit = 1'b1;
    microstep_a = 8'h00;
    step(4);
    chk("min_spd", 12'h000, profile_min_speed);
    chk("lspd", {2'b00, min_speed} >= speed, low_speed_active);
    chk("duty_a", 8'h00, duty_a);
    chk("pwm_a", 1'b0, pwm_a);
    low_speed_optimise_bit = 1'b0;
    step(2);
    chk("min_spd", min_speed, profile_min_speed);
    for (int n = 0; n < 2; n++) begin
      pwm_divider = 3'(n);
      supply_comp_enable = 1'(n);
      wait_strobe();
      wait_strobe();
      t = cyc;
      wait_strobe();
      chk("pwm_per", 16'(pwm_period(n)), 16'(cyc - t));
      step(2);
      chk("adc", converter_input_pin, adc_out);
      chk("vsf", 16'(vsf_exp()), supply_voltage_factor);
    end
    for (int p = 0; p < 4; p++) begin
      motion_phase = sdc_phase_t'(p);
      step(2);
      chk("bemf", 16'(bemf_exp()), backemf_curve_value);
      chk("duty_b", 16'(duty_exp(bemf_exp())), duty_b);
    end
    results();
  end
endmodule : stepper_drive_control_core_tb_top
`default_nettype wire
